// ### hdl/sac_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Result saturates at FFh above high reference, 00h below low, no overflow flag.
// - Conversion is sample loading, then eight approximation steps with sample held.
// - While on, sample and compute repeat back to back without software.
// - A conversion takes twelve converter clocks; converter clock is core clock / 2.
// - Setting converter-on powers up and starts converting the selected input.
// - Each conversion end sets the done flag and a done event; irq rises when that event is unmasked.
// - Result holds until the next conversion finishes, then updates.
// - Control write while on aborts, clears done and restarts a conversion.
// - Done flag bit 7 clears on result read or control write; not writable.
// - Converter-on bit 5: 0 off, 1 on; off stops conversions.
// - Input select bits 3:0 choose analog input 0 to 15 by value.
// - Wait mode leaves converter running; halt mode disables it.
// - Result is read-only 8 bits; both registers reset to zero.
module sac_ctrl
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Low-power state of the core
  input  wire logic        halt_mode,
  // Analog front end and interrupt request
  input  wire logic        comp_above,
  output logic [3:0]       input_select,
  output logic             sample_en,
  output logic             analog_power,
  output logic [7:0]       trial_code,
  output logic             irq
);

  typedef struct packed
  {
    logic                       awready;
    logic                       wready;
    logic                       aw_held;
    logic                       w_held;
    logic [3:0]                 waddr;
    logic [31:0]                wdata;
    logic [3:0]                 wstrb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic                       done_flag;
    logic                       converter_on;
    logic [3:0]                 input_select;
    logic [7:0]                 result_reg;
    logic [sac_pkg::EV_NUM-1:0] irq_mask;
    sac_pkg::sac_seq_t          seq;
    logic [3:0]                 cnt;
    logic [7:0]                 trial;
    logic                       sample_en;
    logic                       analog_power;
    logic                       restart;
  } sac_state_t;

  sac_state_t st;
  sac_state_t next_st;

  logic                       cc_tick;
  logic [sac_pkg::EV_NUM-1:0] ev;
  logic [sac_pkg::EV_NUM-1:0] ev_clr;
  logic [sac_pkg::EV_NUM-1:0] ev_status;
  logic                       irq_raw;
  logic                       run;

  // Halt stops the converter, wait mode has no effect
  assign run = st.converter_on & ~halt_mode;

  sac_cc_div u_div
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (run),
    .tick    (cc_tick)
  );

  sac_irq u_irq
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ev      (ev),
    .clr     (ev_clr),
    .mask    (st.irq_mask),
    .status  (ev_status),
    .irq     (irq_raw)
  );

  // Bus handshake, register file and the conversion sequencer
  always_comb
  begin
    logic       rd_result;
    logic [7:0] wbyte;
    logic [7:0] ctrl_val;
    logic       bit_keep;
    rd_result = 1'b0;
    wbyte     = 8'h00;
    bit_keep  = 1'b0;
    ev        = '0;
    ev_clr    = '0;
    next_st   = st;
    ctrl_val  = {st.done_flag, 1'b0, st.converter_on, 1'b0, st.input_select};
    next_st.restart = 1'b0;

    // Write address and data may arrive in either order
    if (st.awready && s_axi_awvalid)
    begin
      next_st.awready = 1'b0;
      next_st.aw_held = 1'b1;
      next_st.waddr   = s_axi_awaddr;
    end
    if (st.wready && s_axi_wvalid)
    begin
      next_st.wready = 1'b0;
      next_st.w_held = 1'b1;
      next_st.wdata  = s_axi_wdata;
      next_st.wstrb  = s_axi_wstrb;
    end

    // Perform the write once both halves are held and no response pends
    if (st.aw_held && st.w_held && !st.bvalid)
    begin
      wbyte           = st.wdata[7:0];
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = sac_pkg::RESP_OKAY;
      if (st.waddr == sac_pkg::ADDR_CTRL)
      begin
        // Any control write clears done, even with byte lane 0 off
        next_st.done_flag = 1'b0;
        if (st.wstrb[0])
        begin
          next_st.converter_on = wbyte[sac_pkg::ON_BIT];
          next_st.input_select = wbyte[sac_pkg::SEL_MSB:sac_pkg::SEL_LSB];
        end
        // Write while on aborts and restarts
        if (st.converter_on && st.seq != sac_pkg::SEQ_IDLE)
          ev[sac_pkg::EV_ABORT] = 1'b1;
        next_st.restart = 1'b1;
      end
      else if (st.waddr == sac_pkg::ADDR_IRQ_ST)
      begin
        if (st.wstrb[0])
          ev_clr = wbyte[sac_pkg::EV_NUM-1:0];
      end
      else if (st.waddr == sac_pkg::ADDR_IRQ_MSK)
      begin
        if (st.wstrb[0])
          next_st.irq_mask = wbyte[sac_pkg::EV_NUM-1:0];
      end
      else if (st.waddr != sac_pkg::ADDR_RESULT)
        next_st.bresp = sac_pkg::RESP_SLVERR;
      // Result register is read-only; writes are accepted and dropped
    end
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid  = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end

    // Read channel; one read at a time
    if (st.arready && s_axi_arvalid)
    begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rresp   = sac_pkg::RESP_OKAY;
      if (s_axi_araddr == sac_pkg::ADDR_RESULT)
      begin
        next_st.rdata = {24'h000000, st.result_reg};
        rd_result     = 1'b1;
      end
      else if (s_axi_araddr == sac_pkg::ADDR_CTRL)
        next_st.rdata = {24'h000000, ctrl_val};
      else if (s_axi_araddr == sac_pkg::ADDR_IRQ_ST)
        next_st.rdata = {30'h00000000, ev_status};
      else if (s_axi_araddr == sac_pkg::ADDR_IRQ_MSK)
        next_st.rdata = {30'h00000000, st.irq_mask};
      else
      begin
        next_st.rdata = 32'h00000000;
        next_st.rresp = sac_pkg::RESP_SLVERR;
      end
    end
    if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end
    // Result read clears done
    if (rd_result)
      next_st.done_flag = 1'b0;

    // Sequencer: idle while off, restarts on control write
    next_st.analog_power = run;
    if (!run || st.restart)
    begin
      next_st.seq       = sac_pkg::SEQ_IDLE;
      next_st.sample_en = 1'b0;
      next_st.cnt       = 4'h0;
      next_st.trial     = 8'h00;
    end
    else if (cc_tick)
    begin
      case (st.seq)
        sac_pkg::SEQ_IDLE:
        begin
          // First conversion after switch-on or restart
          next_st.seq       = sac_pkg::SEQ_LOAD;
          next_st.cnt       = 4'h1;
          next_st.sample_en = 1'b1;
          next_st.trial     = 8'h00;
        end
        sac_pkg::SEQ_LOAD:
        begin
          if (st.cnt == 4'(sac_pkg::LOAD_CLKS))
          begin
            // Sample isolated while computing; MSB trial first
            next_st.seq       = sac_pkg::SEQ_STEP;
            next_st.sample_en = 1'b0;
            next_st.trial     = 8'h80;
          end
          next_st.cnt = st.cnt + 4'h1;
        end
        sac_pkg::SEQ_STEP:
        begin
          // Keep trial bit if input is above trial code
          bit_keep = comp_above;
          next_st.trial = st.trial;
          if (!bit_keep)
            next_st.trial = st.trial & ~(st.trial & ~(st.trial - 8'h01));
          if (st.cnt == 4'(sac_pkg::CONV_CLKS))
          begin
            // Full-scale and zero saturate naturally, no overflow
            next_st.result_reg = next_st.trial;
            next_st.done_flag  = 1'b1;
            ev[sac_pkg::EV_DONE] = 1'b1;
            // Loop back to sampling with no software action
            next_st.seq       = sac_pkg::SEQ_LOAD;
            next_st.cnt       = 4'h1;
            next_st.sample_en = 1'b1;
          end
          else
          begin
            next_st.trial = next_st.trial | ((st.trial & ~(st.trial - 8'h01)) >> 1);
            next_st.cnt   = st.cnt + 4'h1;
          end
        end
        default:
          next_st.seq = sac_pkg::SEQ_IDLE;
      endcase
    end
  end

  // Single state register; converter clock derived from aclk / 2
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st         <= '0;
      st.awready <= 1'b1;
      st.wready  <= 1'b1;
      st.arready <= 1'b1;
    end
    else
      st <= next_st;
  end

  // Outputs straight from state flops
  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign input_select  = st.input_select;
  assign sample_en     = st.sample_en;
  assign analog_power  = st.analog_power;
  assign trial_code    = st.trial;
  assign irq           = irq_raw;

endmodule
`default_nettype wire

// ### shared/sac_pkg.sv
`default_nettype none
package sac_pkg;

  // Register byte addresses on the AXI4-Lite bus
  localparam logic [3:0] ADDR_RESULT  = 4'h0;
  localparam logic [3:0] ADDR_CTRL    = 4'h4;
  localparam logic [3:0] ADDR_IRQ_ST  = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MSK = 4'hC;

  // Control/status field positions
  localparam int DONE_BIT = 7;
  localparam int ON_BIT   = 5;
  localparam int SEL_MSB  = 3;
  localparam int SEL_LSB  = 0;

  // Writable control bits: converter_on and input_select only
  localparam logic [7:0] CTRL_WMASK  = 8'h2F;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // Conversion timing in converter clock periods, core clocks per converter clock, result bits
  localparam int CONV_CLKS   = 12;
  localparam int LOAD_CLKS   = 4;
  localparam int CORE_PER_CC = 2;
  localparam int RES_BITS    = 8;

  // Interrupt status bits
  localparam int EV_DONE  = 0;
  localparam int EV_ABORT = 1;
  localparam int EV_NUM   = 2;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    SEQ_IDLE = 2'b00,
    SEQ_LOAD = 2'b01,
    SEQ_STEP = 2'b10
  } sac_seq_t;

endpackage
`default_nettype wire

// ### hdl/sac_cc_div.sv
`timescale 1ns/1ps
`default_nettype none
// Converter clock enable at half the core rate; held in phase while off
module sac_cc_div
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic run,
  output logic      tick
);

  typedef struct packed
  {
    logic ph;
    logic tick;
  } sac_div_t;

  sac_div_t st;
  sac_div_t next_st;

  // Tick on every second core edge while running
  always_comb
  begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (!run)
      next_st.ph = 1'b0;
    else
    begin
      next_st.ph   = ~st.ph;
      next_st.tick = st.ph;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.tick;

endmodule
`default_nettype wire

// ### hdl/sac_irq.sv
`timescale 1ns/1ps
`default_nettype none
// Sticky event flags, write one to clear; set beats clear
module sac_irq
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [sac_pkg::EV_NUM-1:0] ev,
  input  wire logic [sac_pkg::EV_NUM-1:0] clr,
  input  wire logic [sac_pkg::EV_NUM-1:0] mask,
  output logic      [sac_pkg::EV_NUM-1:0] status,
  output logic                           irq
);

  typedef struct packed
  {
    logic [sac_pkg::EV_NUM-1:0] status;
    logic                       irq;
  } sac_irq_st_t;

  sac_irq_st_t st;
  sac_irq_st_t next_st;

  always_comb
  begin
    next_st        = st;
    next_st.status = (st.status & ~clr) | ev;
    next_st.irq    = |(next_st.status & mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign status = st.status;
  assign irq    = st.irq;

endmodule
`default_nettype wire

// ### bench/sac_front_model.sv
`timescale 1ns/1ps
`default_nettype none
// Analog mux, sample-and-hold and comparator facing the converter
module sac_front_model
(
  input  wire logic       aclk,
  input  wire logic [3:0] input_select,
  input  wire logic       sample_en,
  input  wire logic       analog_power,
  input  wire logic [7:0] trial_code,
  output logic            comp_above
);
  logic [7:0] level [16];
  logic [7:0] held;
  logic       tog = 1'b0;

  // Cap follows the chosen input only while loading, isolated while computing
  always @(posedge aclk)
  begin
    if (sample_en) held <= level[input_select];
    tog <= ~tog;
  end

  // Unpowered comparator gives no steady answer, so nothing can lean on it
  assign comp_above = analog_power ? (held >= trial_code) : tog;
endmodule
`default_nettype wire

// ### bench/sac_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Pin-level timing relations of the converter control block
module sac_ctrl_chk
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        halt_mode,
  input wire logic [3:0]  input_select,
  input wire logic        sample_en,
  input wire logic        analog_power,
  input wire logic [7:0]  trial_code,
  input wire logic        irq
);
  logic [4:0] cnt;
  logic       se_q;
  logic       wr_ctrl;
  logic [3:0] w_sel;
  logic       w_on;

  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Control write with both channels taken together and lane 0 on, and its fields
  assign wr_ctrl = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                   && (s_axi_awaddr == sac_pkg::ADDR_CTRL) && s_axi_wstrb[0];
  assign w_sel = s_axi_wdata[3:0];
  assign w_on = s_axi_wdata[sac_pkg::ON_BIT];

  // Cycles since loading began; write, halt or power-off drop the count
  always_ff @(posedge aclk)
  begin
    se_q <= sample_en;
    if (!aresetn || s_axi_bvalid || halt_mode || !analog_power)
      cnt <= 5'h00;
    else if (sample_en && !se_q)
      cnt <= 5'h01;
    else if ((cnt != 5'h00) && (cnt != 5'h1F))
      cnt <= cnt + 5'h01;
  end

  // Bus, sequencer and front-end relations
  a_reset_clear: assert property (disable iff (1'b0) !aresetn |=>
    !analog_power && !sample_en && !irq && (input_select == 4'h0))
    else $error("reset state wrong");
  a_load_span: assert property ((cnt != 5'h00) && (cnt <= 5'h08) && !s_axi_bvalid
    |-> sample_en == (cnt != 5'h08)) else $error("load phase length wrong");
  a_conv_period: assert property ((cnt >= 5'h09) && (cnt <= 5'h18) && !s_axi_bvalid
    |-> sample_en == (cnt == 5'h18)) else $error("conversion period wrong");
  a_halt_stop: assert property (halt_mode |=> !analog_power && !sample_en)
    else $error("converter runs in halt");
  a_off_quiet: assert property (!analog_power [*2] |-> !sample_en)
    else $error("sampling while off");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && (s_axi_rdata[31:8] == 24'h000000)) else $error("read answer wrong");
  a_select_write: assert property (wr_ctrl |-> ##4 input_select == $past(w_sel, 4))
    else $error("input select not applied");
  a_power_write: assert property (wr_ctrl && !halt_mode |->
    ##4 analog_power == $past(w_on, 4)) else $error("converter power not applied");
  a_msb_first: assert property ((cnt == 5'h08) && !s_axi_bvalid |-> trial_code == 8'h80)
    else $error("first trial code wrong");
endmodule

bind sac_ctrl sac_ctrl_chk u_chk (.*);
`default_nettype wire

// ### bench/test_sar_adc_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_control;
  localparam int CONV = sac_pkg::CONV_CLKS * sac_pkg::CORE_PER_CC;
  localparam logic [1:0] OK = sac_pkg::RESP_OKAY;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, halt_mode, comp_above, sample_en, analog_power, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, input_select;
  logic [7:0]  trial_code, last;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [33:0] expq [$];
  int          n_errors, n_checks;

  sac_ctrl u_dut (.*);
  sac_front_model u_front (.*);

  // Core clock, 100 ns period
  always #50 aclk = ~aclk;

  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if ((n_errors == 0) && (n_checks > 0))
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    expq.push_back({er, 32'h00000000});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      aw_ok = aw_ok | s_axi_awready;
      w_ok = w_ok | s_axi_wready;
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  // Read: the expected answer is noted before the request goes out
  task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    expq.push_back({r, 24'h000000, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // Each read or write answer is compared with the oldest note
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready)
      check("read", {s_axi_rresp, s_axi_rdata}, expq.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      check("bresp", {s_axi_bresp, 32'h00000000}, expq.pop_front());
  end

  // Cut a hang short; the full run needs about 1600 cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    stop_test();
  end

  initial
  begin
    aclk = 1'b0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {halt_mode, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    last = 8'h00;
    void'($urandom(32'h3E194B5C));
    // Inputs 0 and 1 sit at the references to show saturation
    for (int i = 0; i < 16; i++)
      u_front.level[i] = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(sac_pkg::ADDR_RESULT, 8'h00, OK);
    rd(sac_pkg::ADDR_CTRL, 8'h00, OK);
    // Every input in turn; each write after the first lands on a running conversion
    for (int c = 0; c < 16; c++)
    begin
      wr(sac_pkg::ADDR_CTRL, 8'h20 | 8'(c), OK);
      rd(sac_pkg::ADDR_RESULT, last, OK);
      rd(sac_pkg::ADDR_CTRL, 8'h20 | 8'(c), OK);
      repeat (2 * CONV + 12) @(posedge aclk);
      rd(sac_pkg::ADDR_CTRL, 8'hA0 | 8'(c), OK);
      rd(sac_pkg::ADDR_RESULT, u_front.level[c], OK);
      last = u_front.level[c];
    end
    // Halt freezes result and flag; release resumes without software
    repeat (CONV + 6) @(posedge aclk);
    halt_mode <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(sac_pkg::ADDR_CTRL, 8'hAF, OK);
    u_front.level[15] = 8'h3C;
    repeat (2 * CONV) @(posedge aclk);
    rd(sac_pkg::ADDR_RESULT, last, OK);
    rd(sac_pkg::ADDR_CTRL, 8'h2F, OK);
    halt_mode <= 1'b0;
    repeat (2 * CONV + 12) @(posedge aclk);
    rd(sac_pkg::ADDR_RESULT, 8'h3C, OK);
    // Off: done cannot be written, result kept
    wr(sac_pkg::ADDR_CTRL, 8'h8F, OK);
    rd(sac_pkg::ADDR_CTRL, 8'h0F, OK);
    u_front.level[15] = 8'hC3;
    repeat (2 * CONV + 12) @(posedge aclk);
    rd(sac_pkg::ADDR_RESULT, 8'h3C, OK);
    wr(sac_pkg::ADDR_RESULT, 8'h55, OK);
    rd(sac_pkg::ADDR_RESULT, 8'h3C, OK);
    wr(4'h2, 8'h01, sac_pkg::RESP_SLVERR);
    rd(4'h2, 8'h00, sac_pkg::RESP_SLVERR);
    // Interrupt raised by done events, masked, then cleared; stale events go first
    wr(sac_pkg::ADDR_IRQ_ST, 8'h03, OK);
    wr(sac_pkg::ADDR_IRQ_MSK, 8'h01, OK);
    rd(sac_pkg::ADDR_IRQ_MSK, 8'h01, OK);
    check("irq", {33'h0, irq}, 34'h0);
    wr(sac_pkg::ADDR_CTRL, 8'h25, OK);
    repeat (2 * CONV + 12) @(posedge aclk);
    check("irq", {33'h0, irq}, 34'h1);
    // Byte lane 0 off: done still clears, fields kept
    s_axi_wstrb <= 4'h0;
    wr(sac_pkg::ADDR_CTRL, 8'h00, OK);
    s_axi_wstrb <= 4'hF;
    rd(sac_pkg::ADDR_CTRL, 8'h25, OK);
    wr(sac_pkg::ADDR_IRQ_MSK, 8'h00, OK);
    repeat (2) @(posedge aclk);
    check("irq", {33'h0, irq}, 34'h0);
    wr(sac_pkg::ADDR_CTRL, 8'h05, OK);
    rd(sac_pkg::ADDR_IRQ_ST, 8'h03, OK);
    wr(sac_pkg::ADDR_IRQ_ST, 8'h03, OK);
    rd(sac_pkg::ADDR_IRQ_ST, 8'h00, OK);
    stop_test();
  end
endmodule
`default_nettype wire
